// [hw/rtf_fill_engine.sv]
`timescale 1ns/100ps
`include "rtf_cfg.svh"

// Summary of operation
// - Three-bit combine field picks how colour merges with existing pixels.
// - Combine code five writes drawing colour, ignoring old pixel contents.
// - Current rectangle uses pen as one corner; needs combine and end only.
// - Current rectangle relative end is offset from pen position.
// - Current rectangle leaves pen position unchanged.
// - Current rectangle spends 135 setup cycles before filling.
// - Explicit triangle takes combine plus three vertices; relative first from pen.
// - Explicit triangle relative second vertex is offset from first vertex.
// - Explicit triangle relative third vertex is offset from first vertex.
// - Explicit triangle loads pen with resolved first vertex at completion.
// - Explicit triangle spends 1021 setup cycles before filling.
// - Triangles are filled one horizontal scan line at a time.
// - Triangle vertices accepted in any order or arrangement.
// - Triangles filled with drawing colour merged per combine field.
// - Current triangle uses pen as first vertex plus two vertex operands.
// - Current triangle relative second and third vertices offset from pen.
// - Current triangle leaves pen position unchanged.
// - Explicit rectangle start relative to pen, end relative to start.
// - Explicit rectangle sets pen to start; 238 setup cycles.
// - Combine supports plain set and exclusive-or with existing pixels.
module rtf_fill_engine #(
  parameter int PIX_W = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Instruction and operand words
  input wire logic i_word_valid,
  input wire logic [15:0] i_word,
  output logic o_word_ready,
  // Drawing colour and pen load
  input wire logic [PIX_W-1:0] i_draw_colour,
  input wire logic i_pen_load,
  input wire rtf_pkg::rtf_vtx_t i_pen_val,
  // Display memory read
  output logic o_rd_valid,
  output rtf_pkg::rtf_vtx_t o_rd_pix,
  input wire logic i_rd_valid,
  input wire logic [PIX_W-1:0] i_rd_data,
  // Display memory write
  output logic o_wr_valid,
  output rtf_pkg::rtf_vtx_t o_wr_pix,
  output logic [PIX_W-1:0] o_wr_data,
  // Status
  output rtf_pkg::rtf_vtx_t o_pen,
  output logic o_busy,
  output logic o_done,
  output logic o_bad_opcode
);
  import rtf_pkg::*;

  if (PIX_W < 1 || PIX_W > 16) begin : g_chk
    $error("PIX_W must be 1 to 16");
  end

  typedef struct packed {
    rtf_state_t state;
    rtf_kind_t kind;
    logic [2:0] comb;
    logic [5:0][15:0] words;
    logic [2:0] wcnt;
    logic [2:0] need;
    rtf_vtx_t pen;
    rtf_vtx_t v0;
    rtf_vtx_t v1;
    rtf_vtx_t v2;
    logic signed [15:0] xmin;
    logic signed [15:0] xmax;
    logic signed [15:0] ymax;
    rtf_vtx_t cur;
    logic word_ready;
    logic busy;
    logic done;
    logic bad_op;
    logic rd_valid;
    logic wr_valid;
    rtf_vtx_t pix;
    logic [PIX_W-1:0] wr_data;
    logic tmr_load;
    logic [10:0] tmr_cycles;
  } rtf_st_t;

  rtf_st_t st_r;
  rtf_st_t st_nxt;

  logic tmr_done;
  logic [PIX_W-1:0] cmb_old;
  logic [PIX_W-1:0] cmb_new;
  logic cmb_read;

  // Operand pair: X word carries the mode flag, Y word follows
  function automatic rtf_vtx_t resolve(input logic [15:0] wx, input logic [15:0] wy,
                                       input rtf_vtx_t base);
    rtf_vtx_t v;
    logic signed [15:0] dx;
    logic signed [15:0] dy;
    dx = {wx[`RTF_X_MSB], wx[`RTF_X_MSB:0]};
    dy = {{2{wy[`RTF_Y_MSB]}}, wy[`RTF_Y_MSB:0]};
    if (wx[`RTF_AM_BIT]) begin
      v.x = base.x + dx;
      v.y = base.y + dy;
    end else begin
      v.x = {1'b0, wx[`RTF_X_MSB:0]};
      v.y = {2'b00, wy[`RTF_Y_MSB:0]};
    end
    return v;
  endfunction

  // Signed side test of point p against edge a to b
  function automatic logic signed [35:0] edge_fn(input rtf_vtx_t a, input rtf_vtx_t b,
                                                 input rtf_vtx_t p);
    logic signed [16:0] px;
    logic signed [16:0] py;
    logic signed [16:0] ex;
    logic signed [16:0] ey;
    logic signed [33:0] m1;
    logic signed [33:0] m2;
    px = 17'(p.x) - 17'(a.x);
    py = 17'(p.y) - 17'(a.y);
    ex = 17'(b.x) - 17'(a.x);
    ey = 17'(b.y) - 17'(a.y);
    m1 = px * ey;
    m2 = py * ex;
    return 36'(m1) - 36'(m2);
  endfunction

  function automatic logic signed [15:0] min3(input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic signed [15:0] c);
    logic signed [15:0] m;
    m = (a < b) ? a : b;
    return (c < m) ? c : m;
  endfunction

  function automatic logic signed [15:0] max3(input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic signed [15:0] c);
    logic signed [15:0] m;
    m = (a > b) ? a : b;
    return (c > m) ? c : m;
  endfunction

  rtf_setup_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_load(st_r.tmr_load),
    .i_cycles(st_r.tmr_cycles),
    .o_done(tmr_done)
  );

  rtf_combine #(
    .PIX_W(PIX_W)
  ) u_combine (
    .i_op(st_r.comb),
    .i_colour(i_draw_colour),
    .i_old(cmb_old),
    .o_new(cmb_new),
    .o_needs_read(cmb_read)
  );

  // No read in flight means the old value is unused
  assign cmb_old = (st_r.state == RTF_RDWAIT) ? i_rd_data : '0;

  logic signed [35:0] e0;
  logic signed [35:0] e1;
  logic signed [35:0] e2;
  logic covered;
  logic is_tri;

  assign is_tri = (st_r.kind == RTF_K_TRI) || (st_r.kind == RTF_K_TRI_CUR);
  assign e0 = edge_fn(st_r.v0, st_r.v1, st_r.cur);
  assign e1 = edge_fn(st_r.v1, st_r.v2, st_r.cur);
  assign e2 = edge_fn(st_r.v2, st_r.v0, st_r.cur);
  // Either winding counts, so vertex order does not matter
  assign covered = (e0 >= 0 && e1 >= 0 && e2 >= 0) || (e0 <= 0 && e1 <= 0 && e2 <= 0);

  always_comb begin
    logic adv;
    rtf_vtx_t a;
    rtf_vtx_t b;
    rtf_vtx_t c;
    adv = 1'b0;
    a = st_r.pen;
    b = st_r.pen;
    c = st_r.pen;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.bad_op = 1'b0;
    st_nxt.rd_valid = 1'b0;
    st_nxt.wr_valid = 1'b0;
    st_nxt.tmr_load = 1'b0;
    if (i_pen_load && st_r.state == RTF_IDLE) begin
      st_nxt.pen = i_pen_val;
    end
    unique case (st_r.state)
      RTF_IDLE: begin
        if (i_word_valid && st_r.word_ready) begin
          st_nxt.comb = i_word[`RTF_CMB_MSB:`RTF_CMB_LSB];
          st_nxt.wcnt = 3'h0;
          st_nxt.state = RTF_FETCH;
          unique case (i_word[`RTF_OPC_MSB:`RTF_OPC_LSB])
            `RTF_OPC_RECT: begin
              st_nxt.kind = RTF_K_RECT;
              st_nxt.need = `RTF_NW_RECT;
            end
            `RTF_OPC_RECT_CUR: begin
              st_nxt.kind = RTF_K_RECT_CUR;
              st_nxt.need = `RTF_NW_RECT_CUR;
            end
            `RTF_OPC_TRI: begin
              st_nxt.kind = RTF_K_TRI;
              st_nxt.need = `RTF_NW_TRI;
            end
            `RTF_OPC_TRI_CUR: begin
              st_nxt.kind = RTF_K_TRI_CUR;
              st_nxt.need = `RTF_NW_TRI_CUR;
            end
            default: begin
              st_nxt.state = RTF_IDLE;
              st_nxt.bad_op = 1'b1;
            end
          endcase
        end
      end
      RTF_FETCH: begin
        if (i_word_valid && st_r.word_ready) begin
          st_nxt.words[st_r.wcnt] = i_word;
          st_nxt.wcnt = st_r.wcnt + 3'h1;
          if (st_r.wcnt + 3'h1 == st_r.need) begin
            st_nxt.word_ready = 1'b0;
            st_nxt.state = RTF_RESOLVE;
          end
        end
      end
      RTF_RESOLVE: begin
        unique case (st_r.kind)
          RTF_K_RECT: begin
            a = resolve(st_r.words[0], st_r.words[1], st_r.pen);
            b = resolve(st_r.words[2], st_r.words[3], a);
            c = a;
            st_nxt.tmr_cycles = `RTF_SETUP_RECT;
          end
          RTF_K_RECT_CUR: begin
            a = st_r.pen;
            b = resolve(st_r.words[0], st_r.words[1], st_r.pen);
            c = a;
            st_nxt.tmr_cycles = `RTF_SETUP_RECT_CUR;
          end
          RTF_K_TRI: begin
            a = resolve(st_r.words[0], st_r.words[1], st_r.pen);
            b = resolve(st_r.words[2], st_r.words[3], a);
            c = resolve(st_r.words[4], st_r.words[5], a);
            st_nxt.tmr_cycles = `RTF_SETUP_TRI;
          end
          RTF_K_TRI_CUR: begin
            a = st_r.pen;
            b = resolve(st_r.words[0], st_r.words[1], st_r.pen);
            c = resolve(st_r.words[2], st_r.words[3], st_r.pen);
            st_nxt.tmr_cycles = `RTF_SETUP_TRI_CUR;
          end
        endcase
        st_nxt.v0 = a;
        st_nxt.v1 = b;
        st_nxt.v2 = c;
        // Bounding box; min and max order the rectangle corners, so any corner order works
        st_nxt.xmin = min3(a.x, b.x, c.x);
        st_nxt.xmax = max3(a.x, b.x, c.x);
        st_nxt.ymax = max3(a.y, b.y, c.y);
        st_nxt.cur.x = min3(a.x, b.x, c.x);
        st_nxt.cur.y = min3(a.y, b.y, c.y);
        st_nxt.tmr_load = 1'b1;
        st_nxt.state = RTF_SETUP;
      end
      RTF_SETUP: begin
        if (tmr_done) begin
          st_nxt.state = RTF_SCAN;
        end
      end
      RTF_SCAN: begin
        // Rectangle covers the whole box; triangle tests each pixel of a row
        if (!is_tri || covered) begin
          st_nxt.pix = st_r.cur;
          if (cmb_read) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.state = RTF_RDWAIT;
          end else begin
            st_nxt.wr_valid = 1'b1;
            st_nxt.wr_data = cmb_new;
            adv = 1'b1;
          end
        end else begin
          adv = 1'b1;
        end
      end
      RTF_RDWAIT: begin
        if (i_rd_valid) begin
          st_nxt.wr_valid = 1'b1;
          st_nxt.wr_data = cmb_new;
          st_nxt.state = RTF_SCAN;
          adv = 1'b1;
        end
      end
      RTF_FINISH: begin
        unique case (st_r.kind)
          RTF_K_RECT: st_nxt.pen = st_r.v0;
          RTF_K_TRI: st_nxt.pen = st_r.v0;
          RTF_K_RECT_CUR: st_nxt.pen = st_r.pen;
          RTF_K_TRI_CUR: st_nxt.pen = st_r.pen;
        endcase
        st_nxt.done = 1'b1;
        st_nxt.word_ready = 1'b1;
        st_nxt.state = RTF_IDLE;
      end
      default: begin
        st_nxt.state = RTF_IDLE;
        st_nxt.word_ready = 1'b1;
      end
    endcase
    // Row-major walk: a whole scan line before the next one
    if (adv) begin
      if (st_r.cur.x >= st_r.xmax) begin
        st_nxt.cur.x = st_r.xmin;
        st_nxt.cur.y = st_r.cur.y + 16'sh0001;
        if (st_r.cur.y >= st_r.ymax) begin
          st_nxt.state = RTF_FINISH;
        end
      end else begin
        st_nxt.cur.x = st_r.cur.x + 16'sh0001;
        if (st_r.state == RTF_RDWAIT) begin
          st_nxt.state = RTF_SCAN;
        end
      end
    end
    // Own flop so the output needs no gate
    st_nxt.busy = !st_nxt.word_ready;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.state <= RTF_IDLE;
      st_r.word_ready <= 1'b1;
      st_r.pen <= {`RTF_COORD_RST, `RTF_COORD_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_word_ready = st_r.word_ready;
  assign o_rd_valid = st_r.rd_valid;
  assign o_rd_pix = st_r.pix;
  assign o_wr_valid = st_r.wr_valid;
  assign o_wr_pix = st_r.pix;
  assign o_wr_data = st_r.wr_data;
  assign o_pen = st_r.pen;
  assign o_busy = st_r.busy;
  assign o_done = st_r.done;
  assign o_bad_opcode = st_r.bad_op;
endmodule

// [hw/rtf_cfg.svh]
`ifndef RTF_CFG_SVH
`define RTF_CFG_SVH

// Instruction word fields
`define RTF_OPC_MSB 7
`define RTF_OPC_LSB 0
`define RTF_CMB_MSB 10
`define RTF_CMB_LSB 8
`define RTF_AM_BIT 15
`define RTF_X_MSB 14
`define RTF_Y_MSB 13

// Opcodes, low byte of the instruction word
`define RTF_OPC_RECT 8'h50
`define RTF_OPC_RECT_CUR 8'h10
`define RTF_OPC_TRI 8'h52
`define RTF_OPC_TRI_CUR 8'h12

// Operand words that follow each opcode
`define RTF_NW_RECT 3'h4
`define RTF_NW_RECT_CUR 3'h2
`define RTF_NW_TRI 3'h6
`define RTF_NW_TRI_CUR 3'h4

// Instruction setup, in system clock cycles
`define RTF_SETUP_RECT 11'h0EE
`define RTF_SETUP_RECT_CUR 11'h087
`define RTF_SETUP_TRI 11'h3FD
`define RTF_SETUP_TRI_CUR 11'h3CA

// Colour combine codes
`define RTF_CMB_SET 3'h0
`define RTF_CMB_OR 3'h1
`define RTF_CMB_AND 3'h2
`define RTF_CMB_XOR 3'h3
`define RTF_CMB_CLR 3'h4
`define RTF_CMB_REPL 3'h5
`define RTF_CMB_ANDN 3'h6
`define RTF_CMB_INV 3'h7

// Reset values
`define RTF_COORD_RST 16'h0000
`define RTF_TMR_RST 11'h000

`endif

// [hw/rtf_pkg.sv]
package rtf_pkg;

  typedef enum logic [2:0] {
    RTF_IDLE = 3'b000,
    RTF_FETCH = 3'b001,
    RTF_RESOLVE = 3'b010,
    RTF_SETUP = 3'b011,
    RTF_SCAN = 3'b100,
    RTF_RDWAIT = 3'b101,
    RTF_FINISH = 3'b110
  } rtf_state_t;

  typedef enum logic [1:0] {
    RTF_K_RECT = 2'b00,
    RTF_K_RECT_CUR = 2'b01,
    RTF_K_TRI = 2'b10,
    RTF_K_TRI_CUR = 2'b11
  } rtf_kind_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
  } rtf_vtx_t;

  typedef struct packed {
    logic [10:0] cnt;
    logic done;
  } rtf_tmr_t;

endpackage

// [hw/rtf_setup_timer.sv]
`timescale 1ns/100ps
`include "rtf_cfg.svh"

module rtf_setup_timer (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire logic i_load,
  input wire logic [10:0] i_cycles,
  // Status
  output logic o_done
);
  import rtf_pkg::*;

  rtf_tmr_t st_r;
  rtf_tmr_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (i_load) begin
      st_nxt.cnt = i_cycles;
    end else if (st_r.cnt != `RTF_TMR_RST) begin
      st_nxt.cnt = st_r.cnt - 11'h001;
      st_nxt.done = (st_r.cnt == 11'h001);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.done;
endmodule

// [hw/rtf_combine.sv]
`timescale 1ns/100ps
`include "rtf_cfg.svh"

module rtf_combine #(
  parameter int PIX_W = 4
) (
  // Operation
  input wire logic [2:0] i_op,
  // Pixel data
  input wire logic [PIX_W-1:0] i_colour,
  input wire logic [PIX_W-1:0] i_old,
  // Result
  output logic [PIX_W-1:0] o_new,
  output logic o_needs_read
);
  import rtf_pkg::*;

  always_comb begin
    o_new = i_colour;
    o_needs_read = 1'b1;
    unique case (i_op)
      `RTF_CMB_SET: begin
        o_new = i_colour;
        o_needs_read = 1'b0;
      end
      `RTF_CMB_OR: o_new = i_old | i_colour;
      `RTF_CMB_AND: o_new = i_old & i_colour;
      `RTF_CMB_XOR: o_new = i_old ^ i_colour;
      `RTF_CMB_CLR: begin
        o_new = '0;
        o_needs_read = 1'b0;
      end
      `RTF_CMB_REPL: begin
        o_new = i_colour;
        o_needs_read = 1'b0;
      end
      `RTF_CMB_ANDN: o_new = i_old & ~i_colour;
      `RTF_CMB_INV: o_new = ~i_old;
    endcase
  end
endmodule

// [tb/rtf_mem_model.sv]
`timescale 1ns/100ps
module rtf_mem_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Read request
  input wire logic i_rd_req,
  input wire rtf_pkg::rtf_vtx_t i_rd_pix,
  // Read answer
  output logic o_rd_valid,
  output logic [3:0] o_rd_data
);
  import rtf_pkg::*;
  rtf_vtx_t addr_r;
  logic pend_r;
  int wait_r;
  int slow_r;
  // Latency cycles 1..4 so prompt and slow answers both occur
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_r <= 1'b0;
      wait_r <= 0;
      slow_r <= 0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 4'h0;
    end else begin
      o_rd_valid <= 1'b0;
      // Bus not driven: toggle so stale data never looks valid
      o_rd_data <= ~o_rd_data;
      if (i_rd_req) begin
        pend_r <= 1'b1;
        addr_r <= i_rd_pix;
        wait_r <= slow_r % 4;
        slow_r <= slow_r + 1;
      end else if (pend_r && wait_r == 0) begin
        pend_r <= 1'b0;
        o_rd_valid <= 1'b1;
        o_rd_data <= addr_r.x[3:0] ^ {addr_r.y[1:0], addr_r.y[3:2]};
      end else if (pend_r) begin
        wait_r <= wait_r - 1;
      end
    end
  end
endmodule

// [tb/rtf_fill_engine_chk.sv]
`timescale 1ns/100ps
`include "rtf_cfg.svh"
module rtf_fill_engine_chk #(
  parameter int PIX_W = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Word port
  input wire logic i_word_valid,
  input wire logic [15:0] i_word,
  input wire logic o_word_ready,
  // Pixel port
  input wire logic [PIX_W-1:0] i_draw_colour,
  input wire logic i_pen_load,
  input wire logic o_rd_valid,
  input wire logic i_rd_valid,
  input wire logic o_wr_valid,
  input wire logic [PIX_W-1:0] o_wr_data,
  // Status
  input wire rtf_pkg::rtf_vtx_t o_pen,
  input wire logic o_busy,
  input wire logic o_done
);
  import rtf_pkg::*;
  logic in_r;
  logic pend_r;
  logic cur;
  logic [7:0] op_r;
  logic [2:0] cmb_r;
  logic [11:0] cnt_r;
  logic [11:0] need;
  always_comb begin
    need = 12'h000;
    case (op_r)
      `RTF_OPC_RECT: need = {1'b0, `RTF_SETUP_RECT};
      `RTF_OPC_RECT_CUR: need = {1'b0, `RTF_SETUP_RECT_CUR};
      `RTF_OPC_TRI: need = {1'b0, `RTF_SETUP_TRI};
      `RTF_OPC_TRI_CUR: need = {1'b0, `RTF_SETUP_TRI_CUR};
      default: need = 12'h000;
    endcase
  end
  assign cur = (op_r == `RTF_OPC_RECT_CUR) || (op_r == `RTF_OPC_TRI_CUR);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_r <= 1'b0;
      pend_r <= 1'b0;
      op_r <= 8'h00;
      cmb_r <= 3'h0;
      cnt_r <= 12'h000;
    end else begin
      if (o_done) in_r <= 1'b0;
      // Opcode may land in the same cycle as the previous done
      if (i_word_valid && o_word_ready && (!in_r || o_done)) begin
        op_r <= i_word[7:0];
        cmb_r <= i_word[10:8];
        in_r <= i_word[7:0] inside {`RTF_OPC_RECT, `RTF_OPC_RECT_CUR, `RTF_OPC_TRI,
                                    `RTF_OPC_TRI_CUR};
      end
      cnt_r <= o_busy ? cnt_r + 12'h001 : 12'h000;
      if (o_rd_valid) pend_r <= 1'b1;
      else if (i_rd_valid) pend_r <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_ready_busy: assert property (o_word_ready == !o_busy) else $error("ready not busy inverse");
  a_done_ready: assert property (o_done |-> o_word_ready ##1 !o_done) else $error("done bad");
  a_setup_time: assert property ((o_wr_valid || o_rd_valid) |-> cnt_r >= need + 12'h002)
    else $error("pixel before setup ends");
  a_pen_cur: assert property (o_busy && in_r && cur |=> $stable(o_pen))
    else $error("pen moved in current form");
  a_pen_late: assert property ($changed(o_pen) |-> o_done || $past(i_pen_load))
    else $error("pen moved outside done");
  a_set_noread: assert property (o_rd_valid |-> !(cmb_r inside {3'h0, 3'h4, 3'h5}))
    else $error("read in plain set");
  a_repl_data: assert property (o_wr_valid && cmb_r == 3'h5 |-> o_wr_data == $past(i_draw_colour))
    else $error("replace data wrong");
  a_one_read: assert property (pend_r |-> !o_rd_valid) else $error("two reads outstanding");
  a_wr_after_rd: assert property (pend_r && i_rd_valid |=> o_wr_valid) else $error("no write");
  a_pix_busy: assert property ((o_wr_valid || o_rd_valid) |-> o_busy) else $error("idle pixel");
endmodule
bind rtf_fill_engine rtf_fill_engine_chk #(.PIX_W(PIX_W)) rtf_fill_engine_chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_word_valid(i_word_valid), .i_word(i_word),
  .o_word_ready(o_word_ready), .i_draw_colour(i_draw_colour), .o_rd_valid(o_rd_valid),
  .i_rd_valid(i_rd_valid), .o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data), .o_pen(o_pen),
  .o_busy(o_busy), .o_done(o_done), .i_pen_load(i_pen_load));

// [tb/rtf_fill_engine_tb.sv]
`timescale 1ns/100ps
`include "rtf_cfg.svh"
module rtf_fill_engine_tb;
  import rtf_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_word_valid = 1'b0;
  logic i_pen_load = 1'b0;
  logic [15:0] i_word = 16'h0000;
  logic [3:0] i_draw_colour = 4'h0;
  rtf_vtx_t i_pen_val = '0;
  logic o_word_ready, o_rd_valid, i_rd_valid, o_wr_valid, o_busy, o_done, o_bad_opcode;
  rtf_vtx_t o_rd_pix, o_wr_pix, o_pen, pen_e;
  logic [3:0] i_rd_data, o_wr_data;
  logic [15:0] ws [6];
  logic [35:0] exp_q [$];
  int n_errors = 0;
  int check_count = 0;
  integer seed = 32'ha6be_01d2;
  always #25 i_clk_sys = ~i_clk_sys;
  rtf_fill_engine #(.PIX_W(4)) rtf_fill_engine_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_word_valid(i_word_valid), .i_word(i_word), .o_word_ready(o_word_ready),
    .i_draw_colour(i_draw_colour), .i_pen_load(i_pen_load), .i_pen_val(i_pen_val),
    .o_rd_valid(o_rd_valid), .o_rd_pix(o_rd_pix), .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid), .o_wr_pix(o_wr_pix),
    .o_wr_data(o_wr_data), .o_pen(o_pen), .o_busy(o_busy), .o_done(o_done),
    .o_bad_opcode(o_bad_opcode));
  rtf_mem_model rtf_mem_model_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_rd_req(o_rd_valid), .i_rd_pix(o_rd_pix), .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data));
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(string what, logic [35:0] e, logic [35:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  function automatic rtf_vtx_t res(logic [15:0] wx, logic [15:0] wy, rtf_vtx_t b);
    rtf_vtx_t v;
    v.x = wx[15] ? b.x + {wx[14], wx[14:0]} : {1'b0, wx[14:0]};
    v.y = wx[15] ? b.y + {{2{wy[13]}}, wy[13:0]} : {2'b00, wy[13:0]};
    return v;
  endfunction
  function automatic int side(rtf_vtx_t a, rtf_vtx_t b, rtf_vtx_t p);
    return (int'(b.x) - a.x) * (int'(p.y) - a.y) - (int'(b.y) - a.y) * (int'(p.x) - a.x);
  endfunction
  function automatic int mn(int a, int b, int c);
    return (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
  endfunction
  function automatic int mx(int a, int b, int c);
    return (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
  endfunction
  function automatic logic [3:0] comb(logic [2:0] op, logic [3:0] c, logic [3:0] o);
    case (op)
      3'h1: return c | o;
      3'h2: return c & o;
      3'h3: return c ^ o;
      3'h4: return 4'h0;
      3'h6: return o & ~c;
      3'h7: return ~o;
      default: return c;
    endcase
  endfunction
  task automatic put_word(logic [15:0] w);
    i_word = w;
    i_word_valid = 1'b1;
    while (o_word_ready !== 1'b1) @(posedge i_clk_sys) #2;
    @(posedge i_clk_sys) #2;
  endtask
  task automatic fill(logic [7:0] opc, logic [2:0] cmb, int nw);
    rtf_vtx_t a, b, c, p;
    bit rect;
    int t, e1, e2, e3;
    rect = (opc == `RTF_OPC_RECT) || (opc == `RTF_OPC_RECT_CUR);
    a = pen_e;
    b = res(ws[0], ws[1], pen_e);
    c = res(ws[2], ws[3], pen_e);
    if (opc == `RTF_OPC_RECT || opc == `RTF_OPC_TRI) begin
      a = b;
      b = res(ws[2], ws[3], a);
      c = res(ws[4], ws[5], a);
      pen_e = a;
    end
    if (rect) c = a;
    for (int y = mn(a.y, b.y, c.y); y <= mx(a.y, b.y, c.y); y++)
      for (int x = mn(a.x, b.x, c.x); x <= mx(a.x, b.x, c.x); x++) begin
        p.x = 16'(x);
        p.y = 16'(y);
        e1 = side(a, b, p);
        e2 = side(b, c, p);
        e3 = side(c, a, p);
        if (rect || (e1 >= 0 && e2 >= 0 && e3 >= 0) || (e1 <= 0 && e2 <= 0 && e3 <= 0))
          exp_q.push_back({p, comb(cmb, i_draw_colour, p.x[3:0] ^ {p.y[1:0], p.y[3:2]})});
      end
    put_word({5'h00, cmb, opc});
    for (int i = 0; i < nw; i++) put_word(ws[i]);
    i_word_valid = 1'b0;
    for (t = 0; t < 4000 && o_done !== 1'b1; t++) @(posedge i_clk_sys) #2;
    check("done", 36'h1, {35'h0, o_done});
    check("pen", {4'h0, pen_e}, {4'h0, o_pen});
    check("pixels left", 36'h0, 36'(exp_q.size()));
  endtask
  always @(posedge i_clk_sys) begin
    if (o_wr_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra write", 36'h0, {o_wr_pix, o_wr_data});
      else check("pixel write", exp_q.pop_front(), {o_wr_pix, o_wr_data});
    end
  end
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
  initial begin
    int t;
    repeat (10) @(posedge i_clk_sys);
    #2 i_rst_n = 1'b1;
    i_draw_colour = 4'h9;
    i_pen_val = {16'h000a, 16'h0014};
    i_pen_load = 1'b1;
    pen_e = i_pen_val;
    @(posedge i_clk_sys) #2;
    i_pen_load = 1'b0;
    // End beyond start; any corner order gives the same pixels
    ws = '{16'h8003, 16'h3ffe, 16'h8002, 16'h0001, 16'h0000, 16'h0000};
    fill(`RTF_OPC_RECT, 3'h0, 4);
    for (int k = 0; k < 8; k++) begin
      i_draw_colour = 4'($random(seed));
      ws[0] = 16'h8001;
      ws[1] = 16'h0001;
      fill(`RTF_OPC_RECT_CUR, 3'(k), 2);
    end
    ws[0] = 16'h0010;
    ws[1] = 16'h0014;
    fill(`RTF_OPC_RECT_CUR, 3'h3, 2);
    ws = '{16'h001e, 16'h0028, 16'h8006, 16'h0000, 16'hfffe, 16'h0005};
    fill(`RTF_OPC_TRI, 3'h5, 6);
    ws = '{16'hfffc, 16'h0003, 16'h0024, 16'h0026, 16'h0000, 16'h0000};
    fill(`RTF_OPC_TRI_CUR, 3'h1, 4);
    put_word(16'h0077);
    i_word_valid = 1'b0;
    for (t = 0; t < 3 && o_bad_opcode !== 1'b1; t++) @(posedge i_clk_sys) #2;
    check("bad opcode", 36'h1, {35'h0, o_bad_opcode});
    check("idle", 36'h0, {35'h0, o_busy});
    summarize();
  end
endmodule
